// [src/acs_adc_ctl.sv]
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_adc_ctl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic extRefClk,
  input wire logic compIn,
  input wire logic stopMode,
  output logic [4:0] muxSel,
  output logic powerDown,
  output logic sampleEn,
  output logic [9:0] dacCode,
  output logic irqReq
);

  // **************************************************
  // Declarations
  // **************************************************
  acs_pkg::acs_ctl_e state;
  logic flag;
  logic irqEn;
  logic contConv;
  logic [4:0] chanSel;
  logic [2:0] divSel;
  logic useBusClk;
  logic [1:0] fmtMode;
  logic scanEn;
  logic [1:0] scanLast;
  logic [1:0] scanCnt;
  logic [7:0] resHi;
  logic [7:0] resLo;
  logic [7:0] scanRes [1:3];
  logic locked;
  logic startPulse;
  logic compMeta;
  logic compSync;
  logic convTick;
  logic sarDone;
  logic sarBusy;
  logic sarSampling;
  logic [9:0] sarCode;
  logic [9:0] sarResult;
  logic scWrite;
  logic cfWrite;
  logic rdHi;
  logic rdLo;
  logic wrPowerOff;
  logic validDone;
  logic lastChan;
  logic moreWork;
  logic [15:0] fmtWord;

  assign scWrite = wrEn && addr == `ACS_OFF_STATUS;
  assign cfWrite = wrEn && addr == `ACS_OFF_CLKFMT;
  assign rdHi = rdEn && addr == `ACS_OFF_RESHI;
  assign rdLo = rdEn && addr == `ACS_OFF_RESLO;
  assign wrPowerOff = !scanEn && wrData[`ACS_SC_CHAN_HI:`ACS_SC_CHAN_LO] == `ACS_CHAN_OFF;
  assign validDone = sarDone && state == acs_pkg::ACS_RUN && !scWrite && !startPulse;
  assign lastChan = !scanEn || scanCnt == scanLast;
  assign moreWork = scanEn ? !lastChan : contConv;
  assign fmtWord = fmt_result(fmtMode, sarResult);

  // Result placement by format
  function automatic logic [15:0] fmt_result(input logic [1:0] mode, input logic [9:0] res);
    case (mode)
      acs_pkg::ACS_FMT_TRUNC: fmt_result = {8'h00, res[9:2]};
      acs_pkg::ACS_FMT_RIGHT: fmt_result = {6'h00, res};
      acs_pkg::ACS_FMT_LEFT: fmt_result = {res, 6'h00};
      default: fmt_result = {~res[9], res[8:0], 6'h00};
    endcase
  endfunction

  // **************************************************
  // Comparator synchroniser
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      compMeta <= compIn;
      compSync <= compMeta;
    end
  end

  // **************************************************
  // Converter clock and engine
  // **************************************************
  acs_clk_div u_div (
    .clk(clk),
    .nrst(nrst),
    .useBusClk(useBusClk),
    .divSel(divSel),
    .extRefClk(extRefClk),
    .restart(startPulse),
    .convTick(convTick)
  );

  acs_sar #(.RES_BITS(10)) u_sar (
    .clk(clk),
    .nrst(nrst),
    .tick(convTick),
    .start(startPulse),
    .abort(stopMode),
    .compHigh(compSync),
    .sampling(sarSampling),
    .trialCode(sarCode),
    .done(sarDone),
    .result(sarResult),
    .busy(sarBusy)
  );

  // **************************************************
  // Control registers
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqEn <= 1'b0;
      contConv <= 1'b0;
      chanSel <= `ACS_RST_CHAN;
    end else if (scWrite) begin
      // Done flag position is ignored on write
      irqEn <= wrData[`ACS_SC_IRQEN];
      contConv <= wrData[`ACS_SC_CONT];
      chanSel <= wrData[`ACS_SC_CHAN_HI:`ACS_SC_CHAN_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      divSel <= `ACS_RST_DIV;
      useBusClk <= 1'b0;
      fmtMode <= `ACS_RST_MODE;
    end else if (cfWrite) begin
      divSel <= wrData[`ACS_CF_DIV_HI:`ACS_CF_DIV_LO];
      useBusClk <= wrData[`ACS_CF_SRC];
      fmtMode <= wrData[`ACS_CF_MODE_HI:`ACS_CF_MODE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scanEn <= 1'b0;
      scanLast <= 2'h0;
    end else if (wrEn && addr == `ACS_OFF_SCANCTL) begin
      scanEn <= wrData[`ACS_SCN_EN];
      scanLast <= wrData[`ACS_SCN_LAST_HI:`ACS_SCN_LAST_LO];
    end
  end

  // **************************************************
  // Sequencer
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= acs_pkg::ACS_IDLE;
      startPulse <= 1'b0;
    end else begin
      startPulse <= 1'b0;
      case (state)
        acs_pkg::ACS_IDLE: begin
          if (scWrite && !wrPowerOff) begin
            state <= stopMode ? acs_pkg::ACS_HALT : acs_pkg::ACS_RUN;
            startPulse <= !stopMode;
          end
        end
        acs_pkg::ACS_RUN: begin
          if (scWrite && wrPowerOff) begin
            state <= acs_pkg::ACS_IDLE;
          end else if (stopMode) begin
            state <= acs_pkg::ACS_HALT;
          end else if (scWrite) begin
            startPulse <= 1'b1;
          end else if (validDone) begin
            // Wait mode is not seen here, so conversion runs on
            state <= moreWork ? acs_pkg::ACS_RUN : acs_pkg::ACS_IDLE;
            startPulse <= moreWork;
          end
        end
        acs_pkg::ACS_HALT: begin
          if (scWrite && wrPowerOff) begin
            state <= acs_pkg::ACS_IDLE;
          end else if (!stopMode) begin
            state <= acs_pkg::ACS_RUN;
            startPulse <= 1'b1;
          end
        end
        default: state <= acs_pkg::ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || scWrite) begin
      scanCnt <= 2'h0;
    end else if (validDone && scanEn && !lastChan) begin
      scanCnt <= scanCnt + 2'h1;
    end
  end

  // **************************************************
  // Flags and request
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (validDone && !irqEn) begin
      flag <= 1'b1;
    end else if (scWrite || rdLo) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqReq <= 1'b0;
    end else if (validDone && irqEn && lastChan) begin
      irqReq <= 1'b1;
    end else if (scWrite || rdLo || rdHi) begin
      irqReq <= 1'b0;
    end
  end

  // **************************************************
  // Result storage and interlock
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst || scWrite || cfWrite || rdLo) begin
      locked <= 1'b0;
    end else if (rdHi && fmtMode != acs_pkg::ACS_FMT_TRUNC) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      resHi <= 8'h00;
      resLo <= 8'h00;
    end else if (validDone && !locked) begin
      if (scanEn) begin
        if (scanCnt == 2'h0) begin
          resLo <= sarResult[9:2];
        end
      end else begin
        resHi <= fmtWord[15:8];
        resLo <= fmtWord[7:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_scan
      always_ff @(posedge clk) begin
        if (!nrst) begin
          scanRes[gi] <= 8'h00;
        end else if (validDone && !locked && scanEn && scanCnt == 2'(gi)) begin
          scanRes[gi] <= sarResult[9:2];
        end
      end
    end
  endgenerate

  // **************************************************
  // Read port
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst || !rdEn) begin
      rdData <= 8'h00;
    end else begin
      case (addr)
        `ACS_OFF_STATUS: rdData <= {flag & ~irqEn, irqEn, contConv, chanSel};
        `ACS_OFF_CLKFMT: rdData <= {divSel, useBusClk, fmtMode, 2'h0};
        `ACS_OFF_RESHI: rdData <= resHi;
        `ACS_OFF_RESLO: rdData <= resLo;
        `ACS_OFF_SCAN1: rdData <= scanRes[1];
        `ACS_OFF_SCAN2: rdData <= scanRes[2];
        `ACS_OFF_SCAN3: rdData <= scanRes[3];
        `ACS_OFF_SCANCTL: rdData <= {5'h00, scanEn, scanLast};
        default: rdData <= 8'h00;
      endcase
    end
  end

  // **************************************************
  // Analog front end drive
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      muxSel <= `ACS_RST_CHAN;
      powerDown <= 1'b1;
      sampleEn <= 1'b0;
      dacCode <= 10'h000;
    end else begin
      // Codes 0-7 port pins, 29/30 references, 31 powers down, others reserved
      muxSel <= scanEn ? {3'h0, scanCnt} : chanSel;
      powerDown <= stopMode || (!scanEn && chanSel == `ACS_CHAN_OFF);
      sampleEn <= sarSampling && sarBusy;
      dacCode <= sarCode;
    end
  end

  // **************************************************
  // Checks
  // **************************************************
  logic [4:0] tickCnt;
  always_ff @(posedge clk) begin
    if (!nrst || startPulse) begin
      tickCnt <= 5'h00;
    end else if (convTick && tickCnt != 5'h1F) begin
      tickCnt <= tickCnt + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_flag_zero;
    irqEn |-> rdEn && addr == `ACS_OFF_STATUS |=> !rdData[7];
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("done flag read as one");

  property p_flag_set;
    validDone && !irqEn |=> flag && !irqReq;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");

  property p_irq_set;
    validDone && irqEn && lastChan |=> irqReq && !flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("request not raised");

  property p_irq_clr;
    (scWrite || rdLo) && !validDone |=> !irqReq && !flag;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("request not cleared");

  property p_irq_level;
    irqReq && !scWrite && !rdLo && !rdHi |=> irqReq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("request dropped early");

  property p_start;
    scWrite && !wrPowerOff && !stopMode && state != acs_pkg::ACS_HALT |=> startPulse;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_conv_len;
    sarDone |-> tickCnt == `ACS_CONV_TICKS;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_lock;
    locked && !scWrite && !cfWrite && !rdLo |=> $stable(resLo) && $stable(resHi);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed");

  property p_stop;
    stopMode |=> state != acs_pkg::ACS_RUN ##1 !sarBusy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_signed;
    validDone && !locked && !scanEn && fmtMode == acs_pkg::ACS_FMT_SIGNED
      |=> resHi[7] == ~$past(sarResult[9]);
  endproperty
  a_signed: assert property (p_signed) else $error("sign bit not inverted");

  property p_off;
    scWrite && wrPowerOff |=> state == acs_pkg::ACS_IDLE ##1 powerDown;
  endproperty
  a_off: assert property (p_off) else $error("power off ignored");

  c_cont: cover property (validDone && contConv ##[1:1000] validDone);
  c_scan: cover property (validDone && scanEn && scanLast == 2'h3 && lastChan);
  c_lock: cover property (locked && validDone);
  c_stop: cover property (stopMode && sarBusy ##1 !stopMode [*3]);

endmodule // acs_adc_ctl

// [src/acs_clk_div.sv]
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_clk_div (
  input wire logic clk,
  input wire logic nrst,
  input wire logic useBusClk,
  input wire logic [2:0] divSel,
  input wire logic extRefClk,
  input wire logic restart,
  output logic convTick
);

  logic refMeta;
  logic refSync;
  logic refLast;
  logic inTick;
  logic [3:0] divCnt;
  logic [3:0] divTop;

  // **************************************************
  // External reference edge detect
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refLast <= 1'b0;
    end else begin
      refMeta <= extRefClk;
      refSync <= refMeta;
      refLast <= refSync;
    end
  end

  // Source select
  assign inTick = useBusClk ? 1'b1 : (refSync & ~refLast);

  // Divide ratio minus one
  always_comb begin
    case (divSel)
      3'h0: divTop = 4'h0;
      3'h1: divTop = 4'h1;
      3'h2: divTop = 4'h3;
      3'h3: divTop = 4'h7;
      default: divTop = 4'hF;
    endcase
  end

  // **************************************************
  // Prescaler
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst || restart) begin
      divCnt <= 4'h0;
      convTick <= 1'b0;
    end else if (inTick && divCnt >= divTop) begin
      divCnt <= 4'h0;
      convTick <= 1'b1;
    end else begin
      divCnt <= inTick ? divCnt + 4'h1 : divCnt;
      convTick <= 1'b0;
    end
  end

endmodule // acs_clk_div

// [src/acs_params.svh]
// Behaviour
// - With interrupts enabled, request at each conversion end or scan cycle end.
// - Interrupts off: done flag sets per conversion, clears on result read.
// - Interrupts on: done flag never sets and reads zero.
// - Result read or status write clears pending request; reset clears enable.
// - Continuous bit repeats conversions; clear means one conversion; reset clears.
// - Outside scan, 5-bit channel field; codes 0 to 7 pick port A inputs.
// - Codes 29 and 30 pick internal high and low reference nodes.
// - Codes 8 to 28 are reserved; result undefined.
// - Channel field all ones powers the converter down.
// - In wait mode conversion continues and requests still wake the CPU.
// - Stop mode aborts conversion; conversion resumes after stop ends.
// - 3-bit prescaler divides by 1, 2, 4, 8, or 16 when top bit set.
// - Clock source bit: one bus clock, zero external reference; reset zero.
// - 2-bit format: truncated, right, left, left signed; reset right.
// - Status write starts a conversion lasting 16 to 17 converter clocks.
// - Scan: status write resets counter, converts up to last channel, stops.
// - 10-bit formats: high byte read freezes low byte until read.
// - Left signed format complements the result MSB in the high byte.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register offsets
`define ACS_OFF_STATUS 8'h57
`define ACS_OFF_CLKFMT 8'h58
`define ACS_OFF_RESHI 8'h59
`define ACS_OFF_RESLO 8'h5A
`define ACS_OFF_SCAN1 8'h5B
`define ACS_OFF_SCAN2 8'h5C
`define ACS_OFF_SCAN3 8'h5D
`define ACS_OFF_SCANCTL 8'h5E

// Status control fields
`define ACS_SC_FLAG 7
`define ACS_SC_IRQEN 6
`define ACS_SC_CONT 5
`define ACS_SC_CHAN_HI 4
`define ACS_SC_CHAN_LO 0

// Clock and format control fields
`define ACS_CF_DIV_HI 7
`define ACS_CF_DIV_LO 5
`define ACS_CF_SRC 4
`define ACS_CF_MODE_HI 3
`define ACS_CF_MODE_LO 2

// Scan control fields
`define ACS_SCN_EN 2
`define ACS_SCN_LAST_HI 1
`define ACS_SCN_LAST_LO 0

// Reset values
`define ACS_RST_CHAN 5'h1F
`define ACS_RST_DIV 3'h0
`define ACS_RST_MODE 2'h1
`define ACS_CHAN_OFF 5'h1F

// Conversion timing in converter clocks
`define ACS_CONV_TICKS 5'h10
`define ACS_SAMPLE_TICKS 5'h06

`endif

// [src/acs_pkg.sv]
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_RUN = 2'b01,
    ACS_HALT = 2'b10
  } acs_ctl_e;

  typedef enum logic [1:0] {
    ACS_FMT_TRUNC = 2'b00,
    ACS_FMT_RIGHT = 2'b01,
    ACS_FMT_LEFT = 2'b10,
    ACS_FMT_SIGNED = 2'b11
  } acs_fmt_e;

  typedef enum logic [1:0] {
    ACS_SAR_IDLE = 2'b00,
    ACS_SAR_SAMPLE = 2'b01,
    ACS_SAR_DECIDE = 2'b10
  } acs_sar_e;

endpackage

// [src/acs_sar.sv]
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sar #(
  parameter int RES_BITS = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic compHigh,
  output logic sampling,
  output logic [RES_BITS-1:0] trialCode,
  output logic done,
  output logic [RES_BITS-1:0] result,
  output logic busy
);

  acs_pkg::acs_sar_e state;
  logic [4:0] phase;
  logic [RES_BITS-1:0] bitPtr;

  assign sampling = (state == acs_pkg::ACS_SAR_SAMPLE);
  assign busy = (state != acs_pkg::ACS_SAR_IDLE);

  // **************************************************
  // Sample then one decision per converter clock
  // **************************************************
  always_ff @(posedge clk) begin
    if (!nrst || abort) begin
      state <= acs_pkg::ACS_SAR_IDLE;
      phase <= 5'h00;
      bitPtr <= '0;
      trialCode <= '0;
      done <= 1'b0;
    end else if (start) begin
      state <= acs_pkg::ACS_SAR_SAMPLE;
      phase <= 5'h00;
      bitPtr <= '0;
      trialCode <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        acs_pkg::ACS_SAR_IDLE: begin
          phase <= 5'h00;
        end
        acs_pkg::ACS_SAR_SAMPLE: begin
          if (tick) begin
            phase <= phase + 5'h01;
            if (phase == `ACS_SAMPLE_TICKS - 5'h01) begin
              state <= acs_pkg::ACS_SAR_DECIDE;
              bitPtr <= {1'b1, {(RES_BITS-1){1'b0}}};
              trialCode <= {1'b1, {(RES_BITS-1){1'b0}}};
            end
          end
        end
        acs_pkg::ACS_SAR_DECIDE: begin
          if (tick) begin
            phase <= phase + 5'h01;
            bitPtr <= bitPtr >> 1;
            // Keep trial bit when input is above trial level
            trialCode <= (compHigh ? trialCode : (trialCode & ~bitPtr)) | (bitPtr >> 1);
            if (phase == `ACS_CONV_TICKS - 5'h01) begin
              state <= acs_pkg::ACS_SAR_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: state <= acs_pkg::ACS_SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result <= '0;
    end else if (state == acs_pkg::ACS_SAR_DECIDE && tick && phase == `ACS_CONV_TICKS - 5'h01) begin
      result <= compHigh ? trialCode : (trialCode & ~bitPtr);
    end
  end

endmodule // acs_sar

// [test/acs_adc_ctl_tb.sv]
`timescale 1ns/1ps
module acs_adc_ctl_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [7:0] rdData;
  logic extRefClk = 1'b0;
  logic compIn = 1'b0;
  logic stopMode = 1'b0;
  logic [4:0] muxSel;
  logic powerDown;
  logic sampleEn;
  logic [9:0] dacCode;
  logic irqReq;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  logic [7:0] lastRd = 8'h00;
  logic [7:0] lfsr = 8'h2A;
  logic [2:0] extCnt = 3'h0;
  logic rdTaken = 1'b0;
  logic cmpBit = 1'b0;
  logic scanCmp = 1'b0;
  logic extRun = 1'b0;
  int numErrors = 0;
  int comparisons = 0;

  acs_adc_ctl acs_adc_ctl_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .extRefClk(extRefClk), .compIn(compIn), .stopMode(stopMode),
    .muxSel(muxSel), .powerDown(powerDown), .sampleEn(sampleEn), .dacCode(dacCode),
    .irqReq(irqReq)
  );

  always #20 clk = ~clk;

  // ****************
  // Analog stand-in and external clock
  // ****************
  always @(posedge clk) begin
    compIn <= scanCmp ? muxSel[0] : cmpBit;
    if (extRun) begin
      extCnt <= extCnt + 3'h1;
    end
    extRefClk <= extCnt[2];
    rdTaken <= rdEn;
  end

  // ****************
  // Read data monitor
  // ****************
  always @(negedge clk) begin
    logic [7:0] e;
    logic [7:0] m;
    if (rdTaken) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      lastRd = rdData;
      if (m != 8'h00) begin
        comparisons++;
        if ((rdData & m) !== (e & m)) begin
          numErrors++;
          $display("wrong value at %0t: got %h expected %h", $time, rdData, e);
        end
      end
    end
  end

  function automatic logic [7:0] nextRnd(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [15:0] fmtRes(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r[9:2], r[1:0], 6'h00};
      default: return {~r[9], r[8:2], r[1:0], 6'h00};
    endcase
  endfunction

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    expQ.push_back(e);
    mskQ.push_back(m);
    @(posedge clk);
    rdEn <= 1'b0;
  endtask

  task automatic waitFlag;
    int n;
    n = 0;
    do begin
      rd(8'h57, 8'h00, 8'h00);
      @(negedge clk);
      #1;
      n++;
    end while (lastRd[7] !== 1'b1 && n < 600);
    chk(lastRd[7], 1'b1);
  endtask

  task automatic waitIrq(output int cyc);
    cyc = 0;
    while (irqReq !== 1'b1 && cyc < 3000) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    numErrors++;
    testDone();
  end

  initial begin
    int cyc;
    int n;
    logic [15:0] ex;
    logic [4:0] ch;
    logic [2:0] divs[6];
    divs = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h57, 8'h1F, 8'hFF);
    rd(8'h58, 8'h04, 8'hFF);
    for (int a = 8'h59; a <= 8'h60; a++) begin
      rd(a[7:0], 8'h00, 8'hFF);
    end
    chk(powerDown, 1'b1);
    chk(irqReq, 1'b0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      lfsr = nextRnd(lfsr);
      ch = {2'b00, lfsr[2:0]};
      cmpBit <= lfsr[3];
      wr(8'h58, {3'h4, 1'b1, m[1:0], 2'b00});
      wr(8'h57, {3'b000, ch});
      repeat (3) @(posedge clk);
      chk(muxSel, ch);
      chk(powerDown, 1'b0);
      chk(sampleEn, 1'b1);
      waitFlag();
      chk(dacCode, {10{lfsr[3]}});
      ex = fmtRes(m[1:0], {10{lfsr[3]}});
      rd(8'h59, ex[15:8], 8'hFF);
      rd(8'h5A, ex[7:0], 8'hFF);
      rd(8'h57, {3'b000, ch}, 8'hFF);
    end
    wr(8'h57, 8'h1D);
    repeat (3) @(posedge clk);
    chk(muxSel, 5'h1D);
    wr(8'h57, 8'h1E);
    repeat (3) @(posedge clk);
    chk(muxSel, 5'h1E);
    wr(8'h57, 8'h1F);
    repeat (3) @(posedge clk);
    chk(powerDown, 1'b1);
    $display("test formats and channels done");
    for (int i = 0; i < 6; i++) begin
      n = divs[i][2] ? 16 : (1 << divs[i]);
      wr(8'h58, {divs[i], 1'b1, 2'b01, 2'b00});
      wr(8'h57, {3'b010, ch});
      waitIrq(cyc);
      chk((cyc >= 16 * n - 2) && (cyc <= 17 * n + 4), 1'b1);
      rd(8'h57, {3'b010, ch}, 8'hFF);
      chk(irqReq, 1'b1);
      rd(8'h5A, 8'h00, 8'h00);
      repeat (2) @(posedge clk);
      chk(irqReq, 1'b0);
    end
    $display("test divider and interrupt done");
    cmpBit <= 1'b1;
    wr(8'h58, 8'h94);
    wr(8'h57, {3'b001, ch});
    waitFlag();
    rd(8'h59, 8'h03, 8'hFF);
    cmpBit <= 1'b0;
    repeat (600) @(posedge clk);
    rd(8'h5A, 8'hFF, 8'hFF);
    waitFlag();
    rd(8'h59, 8'h00, 8'hFF);
    rd(8'h5A, 8'h00, 8'hFF);
    wr(8'h57, 8'h1F);
    $display("test continuous and interlock done");
    wr(8'h57, {3'b010, ch});
    repeat (100) @(posedge clk);
    stopMode <= 1'b1;
    repeat (2) @(posedge clk);
    chk(powerDown, 1'b1);
    repeat (600) @(posedge clk);
    chk(irqReq, 1'b0);
    stopMode <= 1'b0;
    waitIrq(cyc);
    chk((cyc >= 254) && (cyc <= 290), 1'b1);
    // First result after stop is not relied on
    rd(8'h5A, 8'h00, 8'h00);
    $display("test stop done");
    wr(8'h58, 8'h90);
    wr(8'h5E, 8'h07);
    rd(8'h5E, 8'h07, 8'hFF);
    scanCmp <= 1'b1;
    wr(8'h57, 8'h40);
    waitIrq(cyc);
    chk((cyc >= 1000) && (cyc <= 1200), 1'b1);
    chk(muxSel, 5'h03);
    rd(8'h5A, 8'h00, 8'hFF);
    rd(8'h5B, 8'hFF, 8'hFF);
    rd(8'h5C, 8'h00, 8'hFF);
    rd(8'h5D, 8'hFF, 8'hFF);
    scanCmp <= 1'b0;
    wr(8'h5E, 8'h00);
    $display("test scan done");
    // External source stalled, so no conversion may finish
    cmpBit <= 1'b1;
    wr(8'h58, 8'h40);
    wr(8'h57, {3'b000, ch});
    repeat (300) @(posedge clk);
    rd(8'h57, {3'b000, ch}, 8'hFF);
    extRun <= 1'b1;
    waitFlag();
    rd(8'h5A, 8'hFF, 8'hFF);
    $display("test external clock done");
    testDone();
  end
endmodule // acs_adc_ctl_tb
